/* File: hw/rsa_pkg.sv */
/*
 * Shared constants, types and helpers for the rotate, subtract and skip
 * datapath: register offsets, field positions, operation codes, flag layout.
 * Assumes it is compiled before every other file of the block.
 */
// Function
// - Plain left rotate moves bit 7 to bit 0, flags untouched.
// - Accumulator-target rotates write the accumulator (and carry in the through-carry forms), memory byte kept.
// - Left rotate through carry: bit 7 to carry, old carry to bit 0.
// - Plain right rotate moves bit 0 to bit 7, flags untouched.
// - Right rotate through carry: bit 0 to carry, old carry to bit 7.
// - Subtract with borrow is accumulator minus operand minus inverted carry.
// - Subtraction clears carry on negative result, sets it otherwise.
// - Subtractions update overflow, zero, half, carry, signed and zero-chain flags.
// - Plain subtract: memory operand to acc or memory, immediate to acc.
// - Decrement-skip lowers the byte, writes it back, skips on zero.
// - Increment-skip raises the byte, stores it, skips on zero.
// - Accumulator forms of inc/dec-skip write only acc, test acc.
// - Skip instructions take two cycles with a dummy; no flag changes.
// - Byte set forces all ones, bit set forces one bit; no flags.
// - Skip-if-nonzero skips when byte or selected bit is nonzero.
// - Swap exchanges the two nibbles of the byte in place; no flags.
package rsa_pkg;

   // ----------------------------------------------------------------
   // Register map (byte addresses on the APB bus).
   // ----------------------------------------------------------------
   localparam logic [7:0] ADDR_CTRL = 8'h00;
   localparam logic [7:0] ADDR_ACC = 8'h04;
   localparam logic [7:0] ADDR_MEM = 8'h08;
   localparam logic [7:0] ADDR_IMM = 8'h0c;
   localparam logic [7:0] ADDR_FLAGS = 8'h10;
   localparam logic [7:0] ADDR_STATE = 8'h14;

   // ----------------------------------------------------------------
   // Field positions and reset values.
   // ----------------------------------------------------------------
   localparam int CTRL_OP_LSB = 0;
   localparam int CTRL_BIT_LSB = 8;
   localparam int STATE_BUSY_BIT = 0;
   localparam int STATE_SKIP_BIT = 1;
   localparam logic [7:0] BYTE_ZERO = 8'h00;
   localparam logic [7:0] BYTE_ONES = 8'hff;
   localparam logic [7:0] BYTE_ONE = 8'h01;
   localparam logic [31:0] WORD_ZERO = 32'h0000_0000;

   // ----------------------------------------------------------------
   // Operation codes.
   // ----------------------------------------------------------------
   typedef enum logic [4:0] {
      OP_NOP = 5'h00,
      OP_ROTATE_LEFT_MEM = 5'h01,
      OP_ROTATE_LEFT_TO_ACC = 5'h02,
      OP_ROTATE_LEFT_CARRY_MEM = 5'h03,
      OP_ROTATE_LEFT_CARRY_TO_ACC = 5'h04,
      OP_ROTATE_RIGHT_MEM = 5'h05,
      OP_ROTATE_RIGHT_TO_ACC = 5'h06,
      OP_ROTATE_RIGHT_CARRY_MEM = 5'h07,
      OP_ROTATE_RIGHT_CARRY_TO_ACC = 5'h08,
      OP_MINUS_TO_ACC = 5'h09,
      OP_MINUS_IMM_TO_ACC = 5'h0a,
      OP_MINUS_TO_MEM = 5'h0b,
      OP_MINUS_BORROW_TO_ACC = 5'h0c,
      OP_MINUS_BORROW_IMM_TO_ACC = 5'h0d,
      OP_MINUS_BORROW_TO_MEM = 5'h0e,
      OP_DECREMENT_SKIP_ZERO = 5'h0f,
      OP_DECREMENT_SKIP_ZERO_ACC = 5'h10,
      OP_INCREMENT_SKIP_ZERO = 5'h11,
      OP_INCREMENT_SKIP_ZERO_ACC = 5'h12,
      OP_SKIP_NONZERO = 5'h13,
      OP_SKIP_NONZERO_BIT = 5'h14,
      OP_SET_BYTE = 5'h15,
      OP_SET_BIT = 5'h16,
      OP_SWAP_NIBBLES = 5'h17
   } rsa_op_t;

   // Status flags; the packed order is the bit order of the flag register.
   typedef struct packed {
      logic carryZero;
      logic signedCarry;
      logic carry;
      logic halfCarry;
      logic zero;
      logic signedRange;
   } rsa_flags_t;

   localparam rsa_flags_t FLAGS_RESET = '0;

   // A result byte with the flags it produces.
   typedef struct packed {
      logic [7:0] value;
      rsa_flags_t flags;
   } rsa_result_t;

   // Zero test used by several skip and flag decisions.
   function automatic logic isZero(input logic [7:0] v);
      isZero = (v == BYTE_ZERO);
   endfunction

endpackage

/* File: hw/rsa_rotate.sv */
/*
 * One-place rotate of a byte, left or right, plain or through carry.
 * Assumes a purely combinational use; the caller registers the result.
 */
`timescale 1ns/1ps
module rsa_rotate (
   // Operand and mode.
   input wire logic [7:0] operand,
   input wire logic carryIn,
   input wire logic toRight,
   input wire logic viaCarry,
   // Result.
   output logic [7:0] result,
   output logic carryOut
);

   // The bit shifted in is the wrapped bit or the old carry.
   always_comb begin
      if (toRight) begin
         result = {(viaCarry ? carryIn : operand[0]), operand[7:1]};
         carryOut = viaCarry ? operand[0] : carryIn;
      end else begin
         result = {operand[6:0], (viaCarry ? carryIn : operand[7])};
         carryOut = viaCarry ? operand[7] : carryIn;
      end
   end

endmodule

/* File: hw/rsa_subtract.sv */
/*
 * Byte subtractor with borrow input and the full flag set.
 * Assumes a purely combinational use; the caller decides where it lands.
 */
`timescale 1ns/1ps
module rsa_subtract (
   // Operands.
   input wire logic [7:0] minuend,
   input wire logic [7:0] subtrahend,
   input wire logic borrowIn,
   // Zero chaining for multi-byte subtracts.
   input wire logic chainZero,
   input wire logic oldCarryZero,
   // Result.
   output rsa_pkg::rsa_result_t result
);

   logic [8:0] wide;
   logic [4:0] low;

   // A cleared carry means a borrow out, so carry is the inverted borrow.
   always_comb begin
      wide = {1'b0, minuend} - {1'b0, subtrahend} - {8'h00, borrowIn};
      low = {1'b0, minuend[3:0]} - {1'b0, subtrahend[3:0]} - {4'h0, borrowIn};
      result.value = wide[7:0];
      result.flags.carry = ~wide[8];
      result.flags.halfCarry = ~low[4];
      result.flags.signedRange = (minuend[7] ^ subtrahend[7]) & (minuend[7] ^ wide[7]);
      result.flags.signedCarry = result.flags.signedRange ^ wide[7];
      result.flags.zero = rsa_pkg::isZero(wide[7:0]);
      // Chained form keeps zero only if every earlier byte was zero too.
      result.flags.carryZero = rsa_pkg::isZero(wide[7:0]) & (~chainZero | oldCarryZero);
   end

endmodule

/* File: hw/rsa_alu.sv */
/*
 * Rotate, subtract and skip datapath with its accumulator, operand byte,
 * immediate byte and status flags, reached over an APB slave port.
 * Assumes the fetch logic watches the skip and dummy outputs, and that
 * software loads the operand byte before it issues a command.
 */
// Chosen here: the APB slave port and the placing of the registers.
`timescale 1ns/1ps
module rsa_alu (
   // Clock and reset.
   input wire logic ref_clk,
   input wire logic srst,
   // APB slave.
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Towards the fetch logic.
   output logic busy,
   output logic dummyCycle,
   output logic skipNext
);

   // ----------------------------------------------------------------
   // Sequencer states.
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_EXEC = 2'b01,
      ST_DUMMY = 2'b10
   } rsa_state_t;

   rsa_state_t state_ff;
   rsa_state_t nxt_state;
   rsa_pkg::rsa_op_t op_ff;
   logic [2:0] bitSel_ff;
   logic [7:0] acc_ff;
   logic [7:0] mem_ff;
   logic [7:0] imm_ff;
   rsa_pkg::rsa_flags_t flags_ff;
   logic [31:0] prdata_ff;
   logic pready_ff;
   logic pslverr_ff;
   logic busy_ff;
   logic dummyCycle_ff;
   logic skipNext_ff;
   logic lastSkip_ff;

   // ----------------------------------------------------------------
   // Bus decode.
   // ----------------------------------------------------------------
   logic accessEdge;
   logic wrEdge;
   logic mapped;
   logic wrCtrl;
   logic wrAcc;
   logic wrMem;
   logic wrImm;
   logic wrFlags;

   // A write lands only at the edge where the access phase sees ready high.
   assign accessEdge = psel & penable & pready_ff;
   assign wrEdge = accessEdge & pwrite;
   assign mapped = (paddr == rsa_pkg::ADDR_CTRL) | (paddr == rsa_pkg::ADDR_ACC) |
                   (paddr == rsa_pkg::ADDR_MEM) | (paddr == rsa_pkg::ADDR_IMM) |
                   (paddr == rsa_pkg::ADDR_FLAGS) | (paddr == rsa_pkg::ADDR_STATE);
   // Data writes are refused while a command runs, so the datapath never
   // sees its operands change under it.
   assign wrCtrl = wrEdge & ~busy_ff & (paddr == rsa_pkg::ADDR_CTRL);
   assign wrAcc = wrEdge & ~busy_ff & (paddr == rsa_pkg::ADDR_ACC);
   assign wrMem = wrEdge & ~busy_ff & (paddr == rsa_pkg::ADDR_MEM);
   assign wrImm = wrEdge & ~busy_ff & (paddr == rsa_pkg::ADDR_IMM);
   assign wrFlags = wrEdge & ~busy_ff & (paddr == rsa_pkg::ADDR_FLAGS);

   // ----------------------------------------------------------------
   // Arithmetic units.
   // ----------------------------------------------------------------
   logic rotRight;
   logic rotCarry;
   logic [7:0] rotValue;
   logic rotCarryOut;
   logic [7:0] subOperand;
   logic subWithBorrow;
   rsa_pkg::rsa_result_t subResult;

   rsa_rotate u_rotate (
      .operand(mem_ff),
      .carryIn(flags_ff.carry),
      .toRight(rotRight),
      .viaCarry(rotCarry),
      .result(rotValue),
      .carryOut(rotCarryOut)
   );

   rsa_subtract u_subtract (
      .minuend(acc_ff),
      .subtrahend(subOperand),
      .borrowIn(subWithBorrow & ~flags_ff.carry),
      .chainZero(subWithBorrow),
      .oldCarryZero(flags_ff.carryZero),
      .result(subResult)
   );

   // Operand and mode selection for the two units.
   always_comb begin
      rotRight = 1'b0;
      rotCarry = 1'b0;
      subOperand = mem_ff;
      subWithBorrow = 1'b0;
      unique case (op_ff)
         rsa_pkg::OP_ROTATE_LEFT_CARRY_MEM, rsa_pkg::OP_ROTATE_LEFT_CARRY_TO_ACC: begin
            rotCarry = 1'b1;
         end
         rsa_pkg::OP_ROTATE_RIGHT_MEM, rsa_pkg::OP_ROTATE_RIGHT_TO_ACC: begin
            rotRight = 1'b1;
         end
         rsa_pkg::OP_ROTATE_RIGHT_CARRY_MEM, rsa_pkg::OP_ROTATE_RIGHT_CARRY_TO_ACC: begin
            rotRight = 1'b1;
            rotCarry = 1'b1;
         end
         rsa_pkg::OP_MINUS_IMM_TO_ACC: begin
            subOperand = imm_ff;
         end
         rsa_pkg::OP_MINUS_BORROW_TO_ACC, rsa_pkg::OP_MINUS_BORROW_TO_MEM: begin
            subWithBorrow = 1'b1;
         end
         rsa_pkg::OP_MINUS_BORROW_IMM_TO_ACC: begin
            subOperand = imm_ff;
            subWithBorrow = 1'b1;
         end
         default: begin
         end
      endcase
   end

   // ----------------------------------------------------------------
   // Result selection.
   // ----------------------------------------------------------------
   logic [7:0] nxt_acc;
   logic [7:0] nxt_mem;
   rsa_pkg::rsa_flags_t nxt_flags;
   logic nxt_skip;
   logic isSkipOp;
   logic [7:0] bitMask;
   logic [7:0] decValue;
   logic [7:0] incValue;

   assign bitMask = rsa_pkg::BYTE_ONE << bitSel_ff;
   assign decValue = mem_ff - rsa_pkg::BYTE_ONE;
   assign incValue = mem_ff + rsa_pkg::BYTE_ONE;

   // Each command picks its destination; everything not named keeps its value.
   always_comb begin
      nxt_acc = acc_ff;
      nxt_mem = mem_ff;
      nxt_flags = flags_ff;
      nxt_skip = 1'b0;
      isSkipOp = 1'b0;
      unique case (op_ff)
         rsa_pkg::OP_ROTATE_LEFT_MEM, rsa_pkg::OP_ROTATE_RIGHT_MEM: begin
            nxt_mem = rotValue;
         end
         rsa_pkg::OP_ROTATE_LEFT_TO_ACC, rsa_pkg::OP_ROTATE_RIGHT_TO_ACC: begin
            nxt_acc = rotValue;
         end
         rsa_pkg::OP_ROTATE_LEFT_CARRY_MEM, rsa_pkg::OP_ROTATE_RIGHT_CARRY_MEM: begin
            nxt_mem = rotValue;
            nxt_flags.carry = rotCarryOut;
         end
         rsa_pkg::OP_ROTATE_LEFT_CARRY_TO_ACC, rsa_pkg::OP_ROTATE_RIGHT_CARRY_TO_ACC: begin
            nxt_acc = rotValue;
            nxt_flags.carry = rotCarryOut;
         end
         rsa_pkg::OP_MINUS_TO_ACC, rsa_pkg::OP_MINUS_IMM_TO_ACC,
         rsa_pkg::OP_MINUS_BORROW_TO_ACC, rsa_pkg::OP_MINUS_BORROW_IMM_TO_ACC: begin
            nxt_acc = subResult.value;
            nxt_flags = subResult.flags;
         end
         rsa_pkg::OP_MINUS_TO_MEM, rsa_pkg::OP_MINUS_BORROW_TO_MEM: begin
            nxt_mem = subResult.value;
            nxt_flags = subResult.flags;
         end
         rsa_pkg::OP_DECREMENT_SKIP_ZERO: begin
            isSkipOp = 1'b1;
            nxt_mem = decValue;
            nxt_skip = rsa_pkg::isZero(decValue);
         end
         rsa_pkg::OP_DECREMENT_SKIP_ZERO_ACC: begin
            isSkipOp = 1'b1;
            nxt_acc = decValue;
            nxt_skip = rsa_pkg::isZero(decValue);
         end
         rsa_pkg::OP_INCREMENT_SKIP_ZERO: begin
            isSkipOp = 1'b1;
            nxt_mem = incValue;
            nxt_skip = rsa_pkg::isZero(incValue);
         end
         rsa_pkg::OP_INCREMENT_SKIP_ZERO_ACC: begin
            isSkipOp = 1'b1;
            nxt_acc = incValue;
            nxt_skip = rsa_pkg::isZero(incValue);
         end
         rsa_pkg::OP_SKIP_NONZERO: begin
            isSkipOp = 1'b1;
            nxt_skip = ~rsa_pkg::isZero(mem_ff);
         end
         rsa_pkg::OP_SKIP_NONZERO_BIT: begin
            isSkipOp = 1'b1;
            nxt_skip = ~rsa_pkg::isZero(mem_ff & bitMask);
         end
         rsa_pkg::OP_SET_BYTE: begin
            nxt_mem = rsa_pkg::BYTE_ONES;
         end
         rsa_pkg::OP_SET_BIT: begin
            nxt_mem = mem_ff | bitMask;
         end
         rsa_pkg::OP_SWAP_NIBBLES: begin
            nxt_mem = {mem_ff[3:0], mem_ff[7:4]};
         end
         default: begin
         end
      endcase
   end

   // ----------------------------------------------------------------
   // Sequencer.
   // ----------------------------------------------------------------

   // A skip-type command holds one extra cycle for the dummy fetch.
   always_comb begin
      unique case (state_ff)
         ST_IDLE: nxt_state = wrCtrl ? ST_EXEC : ST_IDLE;
         ST_EXEC: nxt_state = isSkipOp ? ST_DUMMY : ST_IDLE;
         ST_DUMMY: nxt_state = ST_IDLE;
         default: nxt_state = ST_IDLE;
      endcase
   end

   always_ff @(posedge ref_clk) begin
      if (srst) begin
         state_ff <= ST_IDLE;
      end else begin
         state_ff <= nxt_state;
      end
   end

   // Busy covers the execute and dummy cycles and gates bus writes.
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         busy_ff <= 1'b0;
      end else begin
         busy_ff <= (nxt_state != ST_IDLE);
      end
   end

   // Dummy marker and skip request stand for the one dummy cycle.
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         dummyCycle_ff <= 1'b0;
         skipNext_ff <= 1'b0;
      end else begin
         dummyCycle_ff <= (state_ff == ST_EXEC) & isSkipOp;
         skipNext_ff <= (state_ff == ST_EXEC) & nxt_skip;
      end
   end

   // The outcome of the last skip-type command stays readable.
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         lastSkip_ff <= 1'b0;
      end else if ((state_ff == ST_EXEC) & isSkipOp) begin
         lastSkip_ff <= nxt_skip;
      end
   end

   // Command latch.
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         op_ff <= rsa_pkg::OP_NOP;
         bitSel_ff <= 3'h0;
      end else if (wrCtrl) begin
         op_ff <= rsa_pkg::rsa_op_t'(pwdata[rsa_pkg::CTRL_OP_LSB +: 5]);
         bitSel_ff <= pwdata[rsa_pkg::CTRL_BIT_LSB +: 3];
      end
   end

   // ----------------------------------------------------------------
   // Data registers.
   // ----------------------------------------------------------------

   // Execution and bus never collide: the bus is shut out while busy.
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         acc_ff <= rsa_pkg::BYTE_ZERO;
      end else if (state_ff == ST_EXEC) begin
         acc_ff <= nxt_acc;
      end else if (wrAcc) begin
         acc_ff <= pwdata[7:0];
      end
   end

   always_ff @(posedge ref_clk) begin
      if (srst) begin
         mem_ff <= rsa_pkg::BYTE_ZERO;
      end else if (state_ff == ST_EXEC) begin
         mem_ff <= nxt_mem;
      end else if (wrMem) begin
         mem_ff <= pwdata[7:0];
      end
   end

   always_ff @(posedge ref_clk) begin
      if (srst) begin
         imm_ff <= rsa_pkg::BYTE_ZERO;
      end else if (wrImm) begin
         imm_ff <= pwdata[7:0];
      end
   end

   // Software may preset the carry before a borrow chain.
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         flags_ff <= rsa_pkg::FLAGS_RESET;
      end else if (state_ff == ST_EXEC) begin
         flags_ff <= nxt_flags;
      end else if (wrFlags) begin
         flags_ff <= rsa_pkg::rsa_flags_t'(pwdata[5:0]);
      end
   end

   // ----------------------------------------------------------------
   // APB answer.
   // ----------------------------------------------------------------
   logic [31:0] readMux;

   always_comb begin
      readMux = rsa_pkg::WORD_ZERO;
      unique case (paddr)
         rsa_pkg::ADDR_CTRL: begin
            readMux[rsa_pkg::CTRL_OP_LSB +: 5] = op_ff;
            readMux[rsa_pkg::CTRL_BIT_LSB +: 3] = bitSel_ff;
         end
         rsa_pkg::ADDR_ACC: readMux[7:0] = acc_ff;
         rsa_pkg::ADDR_MEM: readMux[7:0] = mem_ff;
         rsa_pkg::ADDR_IMM: readMux[7:0] = imm_ff;
         rsa_pkg::ADDR_FLAGS: readMux[5:0] = flags_ff;
         rsa_pkg::ADDR_STATE: begin
            readMux[rsa_pkg::STATE_BUSY_BIT] = busy_ff;
            readMux[rsa_pkg::STATE_SKIP_BIT] = lastSkip_ff;
         end
         default: readMux = rsa_pkg::WORD_ZERO;
      endcase
   end

   // One wait state: ready rises in the second access cycle, so read data
   // and error can come straight from flops.
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         pready_ff <= 1'b0;
         prdata_ff <= rsa_pkg::WORD_ZERO;
         pslverr_ff <= 1'b0;
      end else if (psel & penable & ~pready_ff) begin
         pready_ff <= 1'b1;
         prdata_ff <= pwrite ? rsa_pkg::WORD_ZERO : readMux;
         pslverr_ff <= ~mapped;
      end else begin
         pready_ff <= 1'b0;
         prdata_ff <= rsa_pkg::WORD_ZERO;
         pslverr_ff <= 1'b0;
      end
   end

   assign prdata = prdata_ff;
   assign pready = pready_ff;
   assign pslverr = pslverr_ff;
   assign busy = busy_ff;
   assign dummyCycle = dummyCycle_ff;
   assign skipNext = skipNext_ff;

endmodule

/* File: sim/rsa_fetch_model.sv */
/*
 * Fetch-side model: counts instructions dropped on a taken skip.
 * Assumes the block's clock and reset.
 */
`timescale 1ns/1ps
module rsa_fetch_model (
   // Clock and reset.
   input wire logic ref_clk,
   input wire logic srst,
   // From the datapath.
   input wire logic dummyCycle,
   input wire logic skipNext,
   // Count of skipped instructions.
   output int skipped
);
   // A skip is honoured only inside the dummy slot, never on its own.
   always @(posedge ref_clk) begin
      if (srst) begin
         skipped <= 0;
      end else if (dummyCycle === 1'b1 && skipNext === 1'b1) begin
         skipped <= skipped + 1;
      end
   end
endmodule

/* File: sim/rsa_alu_checker.sv */
/*
 * Port checker for the rotate, subtract and skip datapath.
 * Assumes it is bound to rsa_alu and sees only its ports.
 */
`timescale 1ns/1ps
module rsa_alu_checker (
   // Clock, reset and bus.
   input wire logic ref_clk,
   input wire logic srst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   // Fetch side.
   input wire logic busy,
   input wire logic dummyCycle,
   input wire logic skipNext
);
   // ----------------------------------------------------------------
   // Bus and command timing.
   // ----------------------------------------------------------------
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (srst);
   property p_one_wait;
      psel && penable && !pready && !$past(penable) |=> pready;
   endproperty
   a_one_wait: assert property (p_one_wait) else $error("ready late");
   property p_ready_pulse;
      pready |=> !pready;
   endproperty
   a_ready_pulse: assert property (p_ready_pulse) else $error("ready held");
   property p_unmapped;
      psel && penable && pready && paddr > rsa_pkg::ADDR_STATE |-> pslverr && prdata == '0;
   endproperty
   a_unmapped: assert property (p_unmapped) else $error("unmapped not refused");
   property p_rdata_idle;
      !pready |-> prdata == '0 && !pslverr;
   endproperty
   a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside answer");
   property p_busy_start;
      psel && penable && pready && pwrite && paddr == rsa_pkg::ADDR_CTRL && !busy |=> busy;
   endproperty
   a_busy_start: assert property (p_busy_start) else $error("command not started");
   property p_busy_bound;
      busy |-> ##[1:2] !busy;
   endproperty
   a_busy_bound: assert property (p_busy_bound) else $error("busy too long");
   property p_dummy_tail;
      dummyCycle |-> busy ##1 !busy && !dummyCycle;
   endproperty
   a_dummy_tail: assert property (p_dummy_tail) else $error("dummy slot wrong");
   property p_dummy_after_exec;
      $rose(dummyCycle) |-> $past(busy);
   endproperty
   a_dummy_after_exec: assert property (p_dummy_after_exec) else $error("no exec");
   property p_skip_in_dummy;
      skipNext |-> dummyCycle;
   endproperty
   a_skip_in_dummy: assert property (p_skip_in_dummy) else $error("stray skip");
   property p_skip_dummy;
      psel && penable && pready && pwrite && paddr == rsa_pkg::ADDR_CTRL && !busy &&
         pwdata[4:0] >= rsa_pkg::OP_DECREMENT_SKIP_ZERO &&
         pwdata[4:0] <= rsa_pkg::OP_SKIP_NONZERO_BIT |-> ##2 dummyCycle;
   endproperty
   a_skip_dummy: assert property (p_skip_dummy) else $error("skip op without dummy");
endmodule

bind rsa_alu rsa_alu_checker chk (.ref_clk(ref_clk), .srst(srst), .psel(psel),
   .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
   .pready(pready), .pslverr(pslverr), .busy(busy), .dummyCycle(dummyCycle),
   .skipNext(skipNext));

/* File: sim/rsa_alu_bench.sv */
/*
 * Self-checking bench: random operands through every operation code.
 * Assumes the checker is bound and the fetch model sits on the skip outputs.
 */
`timescale 1ns/1ps
module rsa_alu_bench;
   logic ref_clk = 0, srst = 1, psel = 0, penable = 0, pwrite = 0;
   logic [7:0] paddr = '0;
   logic [31:0] pwdata = '0, prdata;
   logic pready, pslverr, busy, dummyCycle, skipNext;
   int failures = 0, testsRun = 0, seed = 2, skipped, skipsExp = 0;
   logic [32:0] rdQ[$];
   logic skipQ[$];
   logic [7:0] acc, mem, imm;
   logic [5:0] flg;
   logic lastSk = 1'b0;

   always #10 ref_clk = ~ref_clk;

   rsa_alu DUT (.ref_clk(ref_clk), .srst(srst), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .busy(busy), .dummyCycle(dummyCycle), .skipNext(skipNext));
   rsa_fetch_model fetch (.ref_clk(ref_clk), .srst(srst), .dummyCycle(dummyCycle),
      .skipNext(skipNext), .skipped(skipped));

   task automatic print_verdict;
      if (failures == 0 && testsRun > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask

   task automatic chk(input logic [32:0] exp, input logic [32:0] got);
      testsRun++;
      if (got !== exp) begin
         failures++;
         $display("ERROR %0t got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic stall;
      failures++;
      $display("ERROR %0t wait ran out", $time);
      print_verdict();
   endtask

   // One APB transfer; the request is held until ready is seen at an edge.
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge ref_clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge ref_clk);
      penable <= 1'b1;
      do begin
         @(posedge ref_clk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (n >= 20) stall();
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic rd(input logic [7:0] a, input logic [32:0] e);
      rdQ.push_back(e);
      apb(1'b0, a, '0);
   endtask

   // Result byte and flags {cz, sc, c, ac, z, ov} of a subtraction.
   function automatic logic [13:0] sub(input logic [7:0] a, x, input logic bw, chain);
      logic [8:0] d;
      logic [4:0] h;
      logic ov, z;
      d = {1'b0, a} - {1'b0, x} - 9'(bw);
      h = {1'b0, a[3:0]} - {1'b0, x[3:0]} - 5'(bw);
      ov = (a[7] != x[7]) && (d[7] != a[7]);
      z = d[7:0] == 8'h00;
      sub = {d[7:0], chain ? z & flg[5] : z, ov ^ d[7], !d[8], !h[4], z, ov};
   endfunction

   // Predict the command, issue it, wait for the end and read back.
   task automatic cmd(input logic [4:0] op, input logic [2:0] b);
      logic sk;
      int n;
      sk = 1'b0;
      n = 0;
      case (op)
         5'h01: mem = {mem[6:0], mem[7]};
         5'h02: acc = {mem[6:0], mem[7]};
         5'h03: {flg[3], mem} = {mem, flg[3]};
         5'h04: {flg[3], acc} = {mem, flg[3]};
         5'h05: mem = {mem[0], mem[7:1]};
         5'h06: acc = {mem[0], mem[7:1]};
         5'h07: {mem, flg[3]} = {flg[3], mem};
         5'h08: {acc, flg[3]} = {flg[3], mem};
         5'h09: {acc, flg} = sub(acc, mem, 1'b0, 1'b0);
         5'h0a: {acc, flg} = sub(acc, imm, 1'b0, 1'b0);
         5'h0b: {mem, flg} = sub(acc, mem, 1'b0, 1'b0);
         5'h0c: {acc, flg} = sub(acc, mem, !flg[3], 1'b1);
         5'h0d: {acc, flg} = sub(acc, imm, !flg[3], 1'b1);
         5'h0e: {mem, flg} = sub(acc, mem, !flg[3], 1'b1);
         5'h0f: {mem, sk} = {mem - 8'h01, mem == 8'h01};
         5'h10: {acc, sk} = {mem - 8'h01, mem == 8'h01};
         5'h11: {mem, sk} = {mem + 8'h01, mem == 8'hff};
         5'h12: {acc, sk} = {mem + 8'h01, mem == 8'hff};
         5'h13: sk = mem != 8'h00;
         5'h14: sk = mem[b];
         5'h15: mem = 8'hff;
         5'h16: mem[b] = 1'b1;
         5'h17: mem = {mem[3:0], mem[7:4]};
         default: sk = 1'b0;
      endcase
      if (op >= 5'h0f && op <= 5'h14) begin
         skipQ.push_back(sk);
         skipsExp += 32'(sk);
         lastSk = sk;
      end
      apb(1'b1, rsa_pkg::ADDR_CTRL, {21'h0, b, 3'h0, op});
      do begin
         @(negedge ref_clk);
         n++;
      end while (busy !== 1'b0 && n < 10);
      if (n >= 10) stall();
      rd(rsa_pkg::ADDR_ACC, {25'h0, acc});
      rd(rsa_pkg::ADDR_MEM, {25'h0, mem});
      rd(rsa_pkg::ADDR_FLAGS, {27'h0, flg});
      rd(rsa_pkg::ADDR_STATE, {31'h0, lastSk, 1'b0});
   endtask

   // Monitor: oldest note against each read answer and each dummy slot.
   always @(posedge ref_clk) begin
      if (psel && penable && !pwrite && pready === 1'b1 && rdQ.size() > 0) begin
         chk(rdQ.pop_front(), {pslverr, prdata});
      end
      if (dummyCycle === 1'b1 && skipQ.size() > 0) begin
         chk({32'h0, skipQ.pop_front()}, {32'h0, skipNext});
      end
   end

   // Main sequence: reset values, read-only and unmapped places, then every code.
   initial begin
      repeat (20) @(posedge ref_clk);
      srst <= 1'b0;
      for (int a = 0; a <= 24; a += 4) begin
         rd(8'(a), {a == 24, 32'h0});
      end
      apb(1'b1, rsa_pkg::ADDR_STATE, 32'h3);
      apb(1'b1, 8'h18, 32'hff);
      rd(rsa_pkg::ADDR_STATE, '0);
      for (int r = 0; r < 4; r++) begin
         for (int op = 0; op < 32; op++) begin
            acc = 8'($random(seed));
            imm = 8'($random(seed));
            mem = (r == 0) ? 8'h01 : (r == 1) ? 8'hff : 8'($random(seed));
            flg = 6'($random(seed));
            apb(1'b1, rsa_pkg::ADDR_ACC, {24'h0, acc});
            apb(1'b1, rsa_pkg::ADDR_MEM, {24'h0, mem});
            apb(1'b1, rsa_pkg::ADDR_IMM, {24'h0, imm});
            apb(1'b1, rsa_pkg::ADDR_FLAGS, {26'h0, flg});
            cmd(5'(op), 3'($random(seed)));
         end
      end
      repeat (4) @(posedge ref_clk);
      chk(33'(skipsExp), 33'(skipped));
      chk(33'h0, 33'(skipQ.size()));
      print_verdict();
   end
endmodule
